// [hw/spi_port.v]
// spi master/slave port with ahb-lite register slave
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "spi_port_consts.vh"
module spi_port (
   input wire hclk, // system clock
   input wire hresetn, // async reset, active low
   input wire hsel, // slave select from decoder
   input wire [31:0] haddr, // byte address
   input wire [1:0] htrans, // transfer type
   input wire hwrite, // write not read
   input wire [2:0] hsize, // transfer size
   input wire hready, // bus ready
   input wire [31:0] hwdata, // write data
   output reg [31:0] hrdata, // read data
   output reg hreadyout, // slave ready
   output reg hresp, // response, always okay
   input wire sck_in, // serial clock pin level
   output reg sck_out, // serial clock drive value
   output reg sck_oe_n, // serial clock enable, low drives
   input wire mosi_in, // master-out pin level
   output reg mosi_out, // master-out drive value
   output reg mosi_oe_n, // master-out enable, low drives
   input wire miso_in, // master-in pin level
   output reg miso_out, // master-in drive value
   output reg miso_oe_n, // master-in enable, low drives
   input wire ss_in, // select pin level
   output reg ss_out, // select drive value in gpio mode
   output reg ss_oe_n, // select enable in gpio mode
   output reg irq // transfer-done interrupt
);
   // one shift phase per half bit time: the lead phase samples, the trail phase shifts
   localparam ST_IDLE = 2'h0;
   localparam ST_LEAD = 2'h1;
   localparam ST_TRAIL = 2'h2;

   reg [8:0] ctrl_ff;
   reg done_ff;
   reg write_collision_flag_ff;
   reg [7:0] shift_ff;
   reg [7:0] rbuf_ff; // parallel read buffer, second receive stage
   reg [1:0] state_ff;
   reg [2:0] bit_cnt_ff;
   reg [6:0] div_cnt_ff;
   reg sck_d_ff;
   reg sample_ff;
   reg [7:0] gpio_out_ff;
   reg [7:0] gpio_oe_n_ff;
   reg wr_pend_ff;
   reg rd_pend_ff;
   reg [11:0] addr_ff;
   reg [6:0] half_lim;
   reg [31:0] nxt_rdata;
   reg nxt_sck_oe_n;
   reg nxt_mosi_out;
   reg nxt_mosi_oe_n;
   reg nxt_miso_out;
   reg nxt_miso_oe_n;
   reg nxt_ss_out;
   reg nxt_ss_oe_n;

   wire port_en = ctrl_ff[`CTL_PORT_EN];
   wire ign_sel = ctrl_ff[`CTL_IGN_SEL];
   wire is_master = ctrl_ff[`CTL_MASTER];
   wire clock_polarity = ctrl_ff[`CTL_CLOCK_POLARITY];
   wire clock_phase = ctrl_ff[`CTL_CLOCK_PHASE];
   wire lsb_first = ctrl_ff[`CTL_BIT_ORDER];
   // an enabled master only acts as master while its select pin is high or ignored
   wire master_mode = port_en & is_master & (ign_sel | ss_in);
   wire slave_sel = port_en & ~is_master & (ign_sel | ~ss_in);
   // busy covers the whole byte so a collision is caught from the first half bit
   wire busy = (state_ff != ST_IDLE);
   wire forced_slave = port_en & ~ign_sel & is_master & ~ss_in;
   wire out_bit = lsb_first ? shift_ff[0] : shift_ff[7];
   wire addr_ph = hsel & hready & htrans[1];
   wire data_wr = wr_pend_ff & (addr_ff == `OFS_DATA);
   wire div_tick = (div_cnt_ff == half_lim);
   // slave clock edges, detected on the raw pin level against its registered copy
   // the far clock must stay below half of hclk or an edge is missed
   wire sck_rise = sck_in & ~sck_d_ff;
   wire sck_fall = ~sck_in & sck_d_ff;
   wire s_lead = slave_sel & (clock_polarity ? sck_fall : sck_rise);
   wire s_trail = slave_sel & (clock_polarity ? sck_rise : sck_fall);
   wire lead_edge = master_mode ? div_tick : (clock_phase ? s_trail : s_lead);
   wire trail_edge = master_mode ? div_tick : (clock_phase ? s_lead : s_trail);

   wire ctrl_wr = wr_pend_ff & (addr_ff == `OFS_CTRL);
   wire stat_wr = wr_pend_ff & (addr_ff == `OFS_STAT);
   wire gpio_wr = wr_pend_ff & (addr_ff == `OFS_GPIO);
   // a mode change is only taken between bytes; a byte in flight is abandoned to idle when select falls
   wire mode_drop = forced_slave & ~busy;
   wire last_edge = (state_ff == ST_TRAIL) & (bit_cnt_ff == 3'h7) & trail_edge;
   wire done_set = last_edge | mode_drop;
   wire done_clr = stat_wr & hwdata[`STAT_DONE];
   wire write_collision_flag_set = data_wr & busy;
   wire write_collision_flag_clr = stat_wr & hwdata[`STAT_WRITE_COLLISION_FLAG];

   always @* begin
      case (ctrl_ff[1:0])
         2'b00: half_lim = `HALF_DIV4;
         2'b01: half_lim = `HALF_DIV16;
         2'b10: half_lim = `HALF_DIV64;
         default: half_lim = `HALF_DIV128;
      endcase
   end

   // read data is fetched in the address phase so it stands through the data phase
   always @* begin
      nxt_rdata = 32'h00000000;
      case (haddr[11:0])
         `OFS_CTRL: nxt_rdata = {23'h000000, ctrl_ff};
         `OFS_DATA: nxt_rdata = {24'h000000, rbuf_ff};
         `OFS_STAT: nxt_rdata = {24'h000000, done_ff, write_collision_flag_ff, 6'h00};
         `OFS_GPIO: nxt_rdata = {12'h000, ss_in, sck_in, miso_in, mosi_in, gpio_oe_n_ff, gpio_out_ff};
         default: nxt_rdata = 32'h00000000;
      endcase
   end

   // one step of the shift register in the selected bit order
   function [7:0] shift_in;
      input [7:0] v;
      input lsbf;
      input b;
      begin
         shift_in = lsbf ? {b, v[7:1]} : {v[6:0], b};
      end
   endfunction

   // bus slave: zero wait states, data phase answers in the next cycle
   // hreadyout never drops, every register answers within its data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 12'h000;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_ff <= addr_ph & hwrite;
         rd_pend_ff <= addr_ph & ~hwrite;
         if (addr_ph) begin
            addr_ff <= haddr[11:0];
         end
         if (addr_ph & ~hwrite) begin
            hrdata <= nxt_rdata;
         end
      end
   end

   // control, status and gpio registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= `CTRL_RESET;
         done_ff <= 1'b0;
         write_collision_flag_ff <= 1'b0;
         gpio_out_ff <= 8'h00;
         gpio_oe_n_ff <= 8'hff;
         irq <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            ctrl_ff <= hwdata[8:0];
         end else if (mode_drop) begin
            ctrl_ff[`CTL_MASTER] <= 1'b0;
         end
         if (gpio_wr) begin
            gpio_out_ff <= hwdata[7:0];
            gpio_oe_n_ff <= hwdata[15:8];
         end
         // hardware sets win over software clears
         if (done_set) begin
            done_ff <= 1'b1;
         end else if (done_clr) begin
            done_ff <= 1'b0;
         end
         // the colliding byte never reaches the shift register, only this flag records it
         if (write_collision_flag_set) begin
            write_collision_flag_ff <= 1'b1;
         end else if (write_collision_flag_clr) begin
            write_collision_flag_ff <= 1'b0;
         end
         // irq trails the done flag by one cycle so that it comes straight from a flop
         irq <= done_ff & ctrl_ff[`CTL_IRQ_EN];
      end
   end

   // shift engine; one phase per half bit time
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 3'h0;
         div_cnt_ff <= 7'h00;
         shift_ff <= 8'h00;
         rbuf_ff <= 8'h00;
         sck_d_ff <= 1'b0;
         sample_ff <= 1'b0;
         sck_out <= 1'b0;
      end else begin
         sck_d_ff <= sck_in;
         // the divider only runs during a master byte, so the first half bit is a full one
         div_cnt_ff <= (busy & master_mode & ~div_tick) ? div_cnt_ff + 7'h01 : 7'h00;
         case (state_ff)
            ST_IDLE: begin
               sck_out <= clock_polarity;
               bit_cnt_ff <= 3'h0;
               // a byte written while idle as slave waits here for the far master
               if (data_wr & master_mode) begin
                  shift_ff <= hwdata[7:0];
                  state_ff <= ST_LEAD;
               end else if (data_wr & ~slave_sel) begin
                  shift_ff <= hwdata[7:0];
               end else if (data_wr & slave_sel & ~s_lead & ~s_trail) begin
                  shift_ff <= hwdata[7:0];
               end else if (s_lead & ~clock_phase) begin
                  sample_ff <= clock_phase ? mosi_in : mosi_in;
                  state_ff <= ST_TRAIL;
               end else if (s_lead & clock_phase) begin
                  state_ff <= ST_LEAD;
               end
            end
            ST_LEAD: begin
               // wait for the edge that samples
               if (lead_edge) begin
                  sample_ff <= master_mode ? miso_in : mosi_in;
                  if (master_mode) begin
                     sck_out <= ~sck_out;
                  end
                  state_ff <= ST_TRAIL;
               end else if (~master_mode & ~slave_sel) begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_TRAIL: begin
               if (trail_edge) begin
                  shift_ff <= shift_in(shift_ff, lsb_first, sample_ff);
                  // every bit ends with its trailing edge, so the clock is back at idle after the byte
                  if (master_mode) begin
                     sck_out <= ~sck_out;
                  end
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  // the buffer is overwritten even if unread; software has one byte time to read it
                  if (bit_cnt_ff == 3'h7) begin
                     rbuf_ff <= shift_in(shift_ff, lsb_first, sample_ff);
                     state_ff <= ST_IDLE;
                  end else begin
                     state_ff <= ST_LEAD;
                  end
               end else if (~master_mode & ~slave_sel) begin
                  state_ff <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // pin direction table; gpio when port disabled
   always @* begin
      nxt_sck_oe_n = 1'b1;
      nxt_mosi_out = 1'b0;
      nxt_mosi_oe_n = 1'b1;
      nxt_miso_out = 1'b0;
      nxt_miso_oe_n = 1'b1;
      nxt_ss_out = 1'b0;
      nxt_ss_oe_n = 1'b1;
      if (!port_en) begin
         nxt_sck_oe_n = gpio_oe_n_ff[2];
         nxt_mosi_out = gpio_out_ff[0];
         nxt_mosi_oe_n = gpio_oe_n_ff[0];
         nxt_miso_out = gpio_out_ff[1];
         nxt_miso_oe_n = gpio_oe_n_ff[1];
         nxt_ss_out = gpio_out_ff[3];
         nxt_ss_oe_n = gpio_oe_n_ff[3];
      end else begin
         // the select pin is never driven while the port runs; it is an input in every mode
         nxt_sck_oe_n = ~master_mode;
         nxt_mosi_out = out_bit;
         nxt_mosi_oe_n = ~master_mode;
         nxt_miso_out = out_bit;
         nxt_miso_oe_n = ~slave_sel;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_oe_n <= 1'b1;
         mosi_out <= 1'b0;
         mosi_oe_n <= 1'b1;
         miso_out <= 1'b0;
         miso_oe_n <= 1'b1;
         ss_out <= 1'b0;
         ss_oe_n <= 1'b1;
      end else begin
         sck_oe_n <= nxt_sck_oe_n;
         mosi_out <= nxt_mosi_out;
         mosi_oe_n <= nxt_mosi_oe_n;
         miso_out <= nxt_miso_out;
         miso_oe_n <= nxt_miso_oe_n;
         ss_out <= nxt_ss_out;
         ss_oe_n <= nxt_ss_oe_n;
      end
   end
endmodule

// [pkg/spi_port_consts.vh]
// constants, register map and field layout of the spi port
// What this block does
// - transfers are always started by the current master, never by a slave.
// - enabled master: writing the data register starts the clock and one byte.
// - first master-out bit appears one hclk cycle after the data register loads, before the first clock edge.
// - master and slave shift their bytes out simultaneously, exchanging them.
// - after eight bits the done flag sets; irq raised when enabled.
// - enabled, select honoured, select high, master bit: idle master drives clock and out.
// - idle master with select honoured seeing select low becomes selected slave.
// - forced change clears master bit; device drives miso, takes clock and mosi in.
// - after forced change the device stays slave until software sets master again.
// - transmit holds one byte; receive holds shift register plus read buffer.
// - no new transmit byte is loaded until the current transfer completes.
// - writing data during a transfer sets the write collision flag.
// - on collision the shifting byte continues and the written byte is dropped.
// - a fully received byte is copied into the parallel read buffer.
// - an unread buffered byte is overwritten when the next byte completes.
// - collision flag cleared by writing one; writing zero leaves it.
// - with port disabled mosi, miso and select are plain general-purpose i/o; clock gets only its enable from gpio, its value from polarity.
// - rate bits divide the clock by 4, 16, 64 or 128 in code order.
// - polarity sets idle clock level; phase selects launch and sample edges in slave mode only, a master always samples on its first clock edge.
// - bit order zero shifts msb first, one shifts lsb first, both directions.
`ifndef SPI_PORT_CONSTS_VH
`define SPI_PORT_CONSTS_VH
`define OFS_CTRL 12'h000
`define OFS_DATA 12'h004
`define OFS_STAT 12'h008
`define OFS_GPIO 12'h00c
`define CTL_IGN_SEL 7
`define CTL_PORT_EN 6
`define CTL_BIT_ORDER 5
`define CTL_MASTER 4
`define CTL_CLOCK_POLARITY 3
`define CTL_CLOCK_PHASE 2
`define CTL_IRQ_EN 8
`define STAT_DONE 7
`define STAT_WRITE_COLLISION_FLAG 6
`define CTRL_RESET 9'h000
`define HALF_DIV4 7'h01
`define HALF_DIV16 7'h07
`define HALF_DIV64 7'h1f
`define HALF_DIV128 7'h3f
`endif

// [verification/spi_far_slave.sv]
// far-side spi slave model, mode 0, msb first
`timescale 1ns/100ps
module spi_far_slave (
   input wire sel_n, // select, active low
   input wire sck, // serial clock from master
   input wire mosi, // data from master
   input wire [7:0] tx_byte, // byte handed back
   output wire miso, // data to master
   output reg [7:0] rx_byte = 8'h00 // byte received
);
   reg [7:0] sh = 8'h00;
   reg last = 1'b0;
   // a released line shows the inverse of its last bit so a stale level cannot pass
   assign miso = sel_n ? ~last : sh[7];
   always @(negedge sel_n) sh = tx_byte;
   always @(posedge sel_n) last = sh[7];
   always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
   always @(negedge sck) if (!sel_n) sh = {sh[6:0], 1'b0};
endmodule

// [verification/spi_port_assertions.sv]
// concurrent checks on the spi port pins and bus
`timescale 1ns/100ps
`include "spi_port_consts.vh"
module spi_port_checker (
   input wire hclk, // system clock
   input wire hresetn, // reset, active low
   input wire hsel, // slave select
   input wire [31:0] haddr, // byte address
   input wire [1:0] htrans, // transfer type
   input wire hwrite, // write not read
   input wire [31:0] hwdata, // write data
   input wire hreadyout, // slave ready
   input wire hresp, // response
   input wire sck_out, // clock drive value
   input wire sck_oe_n, // clock enable, low drives
   input wire mosi_out, // master-out drive value
   input wire mosi_oe_n, // master-out enable
   input wire miso_oe_n, // master-in enable
   input wire ss_in, // select pin
   input wire irq // interrupt
);
   reg ph_ff;
   reg [11:0] a_ff;
   reg [8:0] ctl_ff;
   // shadow of the software view of control; hardware clearing of master is not mirrored
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_ff <= 1'b0;
         a_ff <= 12'h000;
         ctl_ff <= 9'h000;
      end else begin
         ph_ff <= hsel & htrans[1] & hwrite & hreadyout;
         a_ff <= haddr[11:0];
         if (ph_ff && a_ff == `OFS_CTRL) ctl_ff <= hwdata[8:0];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_master_pins: assert property (ctl_ff[6] && $past(ctl_ff[6]) && !sck_oe_n |-> !mosi_oe_n && miso_oe_n)
      else $error("master pin directions wrong");
   a_slave_inputs: assert property (ctl_ff[6] && $past(ctl_ff[6]) && sck_oe_n |-> mosi_oe_n)
      else $error("slave drives master-out");
   a_miso_release: assert property ((ctl_ff[6] && !ctl_ff[7] && ss_in)[*4] |-> miso_oe_n)
      else $error("master-in driven while deselected");
   a_forced_slave: assert property (ctl_ff[6] && !ctl_ff[7] && !sck_oe_n && $fell(ss_in)
      |-> ##[1:4] (sck_oe_n && !miso_oe_n)) else $error("no forced slave change");
   a_stay_slave: assert property (ctl_ff[6] && $past(ctl_ff, 2) == ctl_ff && sck_oe_n |=> sck_oe_n)
      else $error("slave became master on its own");
   a_irq_off: assert property (!ctl_ff[8] && !$past(ctl_ff[8]) |-> !irq) else $error("irq while disabled");
   a_mosi_hold: assert property (ctl_ff[6] && !ctl_ff[2] && !sck_oe_n && $rose(sck_out) |-> $stable(mosi_out))
      else $error("master-out moved on sample edge");
   a_half_bit: assert property (ctl_ff[6] && ctl_ff[1:0] == 2'b00 && !sck_oe_n && $rose(sck_out)
      |=> sck_out ##1 !sck_out) else $error("clock high time not two cycles");
endmodule
bind spi_port spi_port_checker spi_port_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .sck_out(sck_out),
   .sck_oe_n(sck_oe_n), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n), .ss_in(ss_in), .irq(irq));

// [verification/spi_port_tb.sv]
// self-checking bench for the spi port
`timescale 1ns/100ps
`include "spi_port_consts.vh"
module spi_port_tb;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg hwrite = 1'b0;
   reg ss_lvl = 1'b1;
   reg psel_n = 1'b1;
   reg [1:0] htrans = 2'b00;
   reg [31:0] haddr = 32'h0;
   reg [31:0] hwdata = 32'h0;
   reg [31:0] q;
   reg [7:0] ptx = 8'h00;
   wire [31:0] hrdata;
   wire [7:0] prx;
   wire hreadyout, hresp, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, ss_out, ss_oe_n, irq, p_miso;
   wire sck_w = !sck_oe_n ? sck_out : 1'b0;
   wire mosi_w = !mosi_oe_n ? mosi_out : 1'b0;
   wire miso_w = !miso_oe_n ? miso_out : p_miso;
   wire ss_w = !ss_oe_n ? ss_out : ss_lvl;
   integer bad_count = 0;
   integer checks = 0;
   spi_port spi_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out),
      .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_in(ss_w),
      .ss_out(ss_out), .ss_oe_n(ss_oe_n), .irq(irq));
   spi_far_slave spi_far_slave_i (.sel_n(psel_n), .sck(sck_w), .mosi(mosi_w), .tx_byte(ptx), .miso(p_miso),
      .rx_byte(prx));
   initial forever #25 hclk = ~hclk;
   task bus(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge hclk);
         hsel <= 1'b1;
         htrans <= 2'b10;
         haddr <= {20'h0, a};
         hwrite <= wr;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= d;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         q = hrdata;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task poll;
      integer n;
      for (n = 0; n < 60; n++) begin
         bus(0, `OFS_STAT, 0);
         if (q[7] === 1'b1) n = 60;
      end
   endtask
   task complete_run;
      begin
         if (bad_count == 0 && checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // a full run is some 150 cycles; a hundred times that means a hang
   initial begin
      #750000;
      bad_count = bad_count + 1;
      complete_run;
   end
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, `OFS_CTRL, 0); chk(q[8:0], `CTRL_RESET);
      bus(1, `OFS_CTRL, 32'h050);
      repeat (3) @(posedge hclk);
      chk({sck_oe_n, mosi_oe_n, miso_oe_n, sck_out}, 4'b0010);
      ptx = 8'h3c;
      psel_n <= 1'b0;
      bus(1, `OFS_DATA, 32'ha5);
      bus(1, `OFS_DATA, 32'h77);
      poll;
      psel_n <= 1'b1;
      chk(q[7:0], 8'hc0);
      bus(1, `OFS_STAT, 0); bus(0, `OFS_STAT, 0); chk(q[7:0], 8'hc0);
      bus(1, `OFS_STAT, 32'hc0); bus(0, `OFS_STAT, 0); chk(q[7:0], 8'h00);
      chk(prx, 8'ha5);
      bus(1, `OFS_CTRL, 32'h070);
      ptx = 8'h0f;
      psel_n <= 1'b0;
      bus(1, `OFS_DATA, 32'h01);
      poll;
      psel_n <= 1'b1;
      chk(prx, 8'h80);
      bus(0, `OFS_DATA, 0); chk(q[7:0], 8'hf0);
      bus(1, `OFS_STAT, 32'hc0);
      bus(1, `OFS_CTRL, 32'h150);
      ss_lvl <= 1'b0;
      repeat (6) @(posedge hclk);
      bus(0, `OFS_CTRL, 0); chk(q[8:0], 9'h140);
      chk({irq, miso_oe_n, sck_oe_n, mosi_oe_n}, 4'b1011);
      bus(0, `OFS_STAT, 0); chk(q[7:0], 8'h80);
      ss_lvl <= 1'b1;
      repeat (6) @(posedge hclk);
      chk({miso_oe_n, sck_oe_n}, 2'b11);
      bus(1, `OFS_CTRL, 0);
      bus(1, `OFS_GPIO, 32'hc03);
      repeat (3) @(posedge hclk);
      chk({mosi_oe_n, mosi_out, sck_oe_n}, 3'b011);
      bus(0, `OFS_GPIO, 0); chk(q[19:16], 4'hb);
      bus(0, 12'h010, 0); chk(q, 0);
      complete_run;
   end
endmodule
